/* File: design/mei_defines.svh */
// Register map, field positions, reset values and timing counts
`ifndef MEI_DEFINES_SVH
`define MEI_DEFINES_SVH

`define MEI_ADDR_TAP_CFG    8'h50
`define MEI_ADDR_TAP_THR    8'h51
`define MEI_ADDR_TAP_DUR    8'h52
`define MEI_ADDR_TAP_LAT    8'h53
`define MEI_ADDR_TAP_WIN    8'h54
`define MEI_ADDR_HLG_CFG    8'h59
`define MEI_ADDR_HIGH_THR   8'h5a
`define MEI_ADDR_HIGH_DUR   8'h5b
`define MEI_ADDR_LOW_THR    8'h5c
`define MEI_ADDR_LOW_DUR    8'h5d
`define MEI_ADDR_FALL_THR   8'h5e
`define MEI_ADDR_FALL_DUR   8'h5f

`define MEI_RST_BYTE        8'h00
`define MEI_TAP_CFG_MASK    8'h0f
`define MEI_HLG_CFG_MASK    8'hf1

`define MEI_TAP_X_BIT       3
`define MEI_TAP_Y_BIT       2
`define MEI_TAP_Z_BIT       1
`define MEI_LINK_BIT        0
`define MEI_HIGH_ALL_BIT    7
`define MEI_HIGH_X_BIT      6
`define MEI_HIGH_Y_BIT      5
`define MEI_HIGH_Z_BIT      4
`define MEI_LOW_ALL_BIT     0

`define MEI_CLK_HZ          50000000
`define MEI_MS_HZ           1000
`define MEI_MS_CYCLES       (`MEI_CLK_HZ / `MEI_MS_HZ)
`define MEI_TICK_HZ         512
`define MEI_TICK_CYCLES     (`MEI_CLK_HZ / `MEI_TICK_HZ)

`endif

/* File: design/mei_pkg.sv */
// Types shared by the motion event block
package mei_pkg;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mei_reg_req_t;

  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
  } mei_axes_t;

  typedef struct packed {
    logic single_tap;
    logic double_tap;
    logic high_g;
    logic low_g;
    logic free_fall;
    logic act;
    logic inact;
  } mei_events_t;

  typedef enum logic [2:0] {
    TAP_IDLE,
    TAP_SHOCK1,
    TAP_LAT,
    TAP_WIN,
    TAP_SHOCK2
  } mei_tap_st_t;

endpackage

/* File: design/mei_motion_events.sv */
// Motion event configuration registers and detectors
// Notes on behaviour
// - Tap detection enabled per axis: X bit 3, Y bit 2, Z bit 1, reset zero.
// - Link bit one: only the opposite of the previous activity state interrupts.
// - Link bit zero: activity and inactivity each interrupt regardless of history.
// - Eight-bit tap threshold, reset zero, compared against acceleration.
// - Eight-bit tap duration in ms bounds how long a tap shock may last.
// - After a first tap, wait programmed latency ms before second-tap window.
// - Window stays open programmed ms; a tap starting inside is a double tap.
// - Bit 7 of high/low-g config is the high-g master enable; the per-axis bits pick the axes, reset zero.
// - High-g per axis enables: X bit 6, Y bit 5, Z bit 4.
// - Bit 0 enables low-g; bits 3 to 1 reserved, no function.
// - High-g threshold weighs 0.5, 1, 2 or 4 mg per count by range.
// - High-g fires after all enabled axes above threshold for programmed 512 Hz ticks.
// - Low-g threshold uses the same range-dependent scaling.
// - Low-g fires after all axes below threshold for programmed 512 Hz ticks.
// - Free-fall threshold uses the same range-dependent scaling.
// - Free-fall fires after all axes below threshold for programmed 512 Hz ticks.
`timescale 1ns/10ps
`include "mei_defines.svh"

module mei_dwell
  import mei_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       arst_n,
  input  wire logic       cond,
  input  wire logic       tick,
  input  wire logic [7:0] limit,
  output logic            fire
);
  logic [7:0] cnt_reg;
  logic       done_reg;
  wire        reached = !done_reg && (cnt_reg >= limit);
  wire        can_cnt = tick && !done_reg && (cnt_reg != 8'hff);

  // One event per uninterrupted interval; done_reg blocks repeats
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg  <= 8'h00;
      done_reg <= 1'b0;
      fire     <= 1'b0;
    end else begin
      fire <= 1'b0;
      if (!cond) begin
        cnt_reg  <= 8'h00;
        done_reg <= 1'b0;
      end else if (reached) begin
        fire     <= 1'b1;
        done_reg <= 1'b1;
      end else if (can_cnt) begin
        cnt_reg <= cnt_reg + 8'h01;
      end
    end
  end

  dwell_restart_a: assert property (@(posedge clock) disable iff (!arst_n)
    !cond |=> (cnt_reg == 8'h00) && !fire)
    else $error("Dwell counter did not restart");
  dwell_fire_a: assert property (@(posedge clock) disable iff (!arst_n)
    fire |-> $past(cond) && ($past(cnt_reg) >= $past(limit)))
    else $error("Dwell fired before its count");
endmodule

module mei_motion_events
  import mei_pkg::*;
#(
  parameter int MS_CYCLES   = `MEI_MS_CYCLES,
  parameter int TICK_CYCLES = `MEI_TICK_CYCLES
) (
  input  wire logic         clock,
  input  wire logic         arst_n,
  input  wire mei_reg_req_t reg_req,
  output logic [7:0]        reg_rdata,
  input  wire logic         sample_valid,
  input  wire mei_axes_t    accel_mag,
  input  wire logic [1:0]   accel_range,
  input  wire logic         act_detect,
  input  wire logic         inact_detect,
  output mei_events_t       events
);
  logic [7:0]  tap_cfg_reg, tap_thr_reg, tap_dur_reg, tap_lat_reg, tap_win_reg;
  logic [7:0]  hlg_cfg_reg, high_thr_reg, high_dur_reg, low_thr_reg, low_dur_reg;
  logic [7:0]  fall_thr_reg, fall_dur_reg;
  logic [16:0] ms_div_reg, tick_div_reg;
  logic        ms_tick_reg, tick_reg;
  logic        tap_hit_reg, tap_prev_reg;
  logic        high_all_reg, low_all_reg, fall_all_reg;
  mei_tap_st_t tap_st_reg, tap_st_next;
  logic [7:0]  tap_ms_reg;
  logic        tap_ms_clr;
  logic        prev_valid_reg, prev_act_reg;
  logic        fire_high, fire_low, fire_fall;
  logic        single_next, double_next;
  mei_events_t evt_next;

  // Register decode
  wire wr_tap_cfg  = reg_req.wr && (reg_req.addr == `MEI_ADDR_TAP_CFG);
  wire wr_tap_thr  = reg_req.wr && (reg_req.addr == `MEI_ADDR_TAP_THR);
  wire wr_tap_dur  = reg_req.wr && (reg_req.addr == `MEI_ADDR_TAP_DUR);
  wire wr_tap_lat  = reg_req.wr && (reg_req.addr == `MEI_ADDR_TAP_LAT);
  wire wr_tap_win  = reg_req.wr && (reg_req.addr == `MEI_ADDR_TAP_WIN);
  wire wr_hlg_cfg  = reg_req.wr && (reg_req.addr == `MEI_ADDR_HLG_CFG);
  wire wr_high_thr = reg_req.wr && (reg_req.addr == `MEI_ADDR_HIGH_THR);
  wire wr_high_dur = reg_req.wr && (reg_req.addr == `MEI_ADDR_HIGH_DUR);
  wire wr_low_thr  = reg_req.wr && (reg_req.addr == `MEI_ADDR_LOW_THR);
  wire wr_low_dur  = reg_req.wr && (reg_req.addr == `MEI_ADDR_LOW_DUR);
  wire wr_fall_thr = reg_req.wr && (reg_req.addr == `MEI_ADDR_FALL_THR);
  wire wr_fall_dur = reg_req.wr && (reg_req.addr == `MEI_ADDR_FALL_DUR);

  // Unmapped addresses read zero
  wire [7:0] rd_mux =
    (reg_req.addr == `MEI_ADDR_TAP_CFG)  ? tap_cfg_reg  :
    (reg_req.addr == `MEI_ADDR_TAP_THR)  ? tap_thr_reg  :
    (reg_req.addr == `MEI_ADDR_TAP_DUR)  ? tap_dur_reg  :
    (reg_req.addr == `MEI_ADDR_TAP_LAT)  ? tap_lat_reg  :
    (reg_req.addr == `MEI_ADDR_TAP_WIN)  ? tap_win_reg  :
    (reg_req.addr == `MEI_ADDR_HLG_CFG)  ? hlg_cfg_reg  :
    (reg_req.addr == `MEI_ADDR_HIGH_THR) ? high_thr_reg :
    (reg_req.addr == `MEI_ADDR_HIGH_DUR) ? high_dur_reg :
    (reg_req.addr == `MEI_ADDR_LOW_THR)  ? low_thr_reg  :
    (reg_req.addr == `MEI_ADDR_LOW_DUR)  ? low_dur_reg  :
    (reg_req.addr == `MEI_ADDR_FALL_THR) ? fall_thr_reg :
    (reg_req.addr == `MEI_ADDR_FALL_DUR) ? fall_dur_reg : 8'h00;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tap_cfg_reg  <= `MEI_RST_BYTE;
      tap_thr_reg  <= `MEI_RST_BYTE;
      tap_dur_reg  <= `MEI_RST_BYTE;
      tap_lat_reg  <= `MEI_RST_BYTE;
      tap_win_reg  <= `MEI_RST_BYTE;
      hlg_cfg_reg  <= `MEI_RST_BYTE;
      high_thr_reg <= `MEI_RST_BYTE;
      high_dur_reg <= `MEI_RST_BYTE;
      low_thr_reg  <= `MEI_RST_BYTE;
      low_dur_reg  <= `MEI_RST_BYTE;
      fall_thr_reg <= `MEI_RST_BYTE;
      fall_dur_reg <= `MEI_RST_BYTE;
      reg_rdata    <= 8'h00;
    end else begin
      if (wr_tap_cfg)  tap_cfg_reg  <= reg_req.wdata & `MEI_TAP_CFG_MASK;
      if (wr_tap_thr)  tap_thr_reg  <= reg_req.wdata;
      if (wr_tap_dur)  tap_dur_reg  <= reg_req.wdata;
      if (wr_tap_lat)  tap_lat_reg  <= reg_req.wdata;
      if (wr_tap_win)  tap_win_reg  <= reg_req.wdata;
      if (wr_hlg_cfg)  hlg_cfg_reg  <= reg_req.wdata & `MEI_HLG_CFG_MASK;
      if (wr_high_thr) high_thr_reg <= reg_req.wdata;
      if (wr_high_dur) high_dur_reg <= reg_req.wdata;
      if (wr_low_thr)  low_thr_reg  <= reg_req.wdata;
      if (wr_low_dur)  low_dur_reg  <= reg_req.wdata;
      if (wr_fall_thr) fall_thr_reg <= reg_req.wdata;
      if (wr_fall_dur) fall_dur_reg <= reg_req.wdata;
      if (reg_req.rd)  reg_rdata    <= rd_mux;
    end
  end

  // Millisecond and 512 Hz enables; the 512 Hz rate is truncated to whole cycles
  wire ms_wrap   = (ms_div_reg == 17'(MS_CYCLES - 1));
  wire tick_wrap = (tick_div_reg == 17'(TICK_CYCLES - 1));

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ms_div_reg   <= 17'h00000;
      tick_div_reg <= 17'h00000;
      ms_tick_reg  <= 1'b0;
      tick_reg     <= 1'b0;
    end else begin
      ms_div_reg   <= ms_wrap ? 17'h00000 : ms_div_reg + 17'h00001;
      tick_div_reg <= tick_wrap ? 17'h00000 : tick_div_reg + 17'h00001;
      ms_tick_reg  <= ms_wrap;
      tick_reg     <= tick_wrap;
    end
  end

  // Thresholds are in range units; samples arrive in 0.5 mg counts, so shift by range
  wire [15:0] tap_lvl  = {8'h00, tap_thr_reg} << accel_range;
  wire [15:0] high_lvl = {8'h00, high_thr_reg} << accel_range;
  wire [15:0] low_lvl  = {8'h00, low_thr_reg} << accel_range;
  wire [15:0] fall_lvl = {8'h00, fall_thr_reg} << accel_range;

  wire [2:0] tap_en  = {tap_cfg_reg[`MEI_TAP_X_BIT], tap_cfg_reg[`MEI_TAP_Y_BIT],
                        tap_cfg_reg[`MEI_TAP_Z_BIT]};
  wire [2:0] high_en = {hlg_cfg_reg[`MEI_HIGH_X_BIT], hlg_cfg_reg[`MEI_HIGH_Y_BIT],
                        hlg_cfg_reg[`MEI_HIGH_Z_BIT]};
  wire [2:0] tap_over  = {accel_mag.x > tap_lvl, accel_mag.y > tap_lvl,
                          accel_mag.z > tap_lvl};
  wire [2:0] high_over = {accel_mag.x > high_lvl, accel_mag.y > high_lvl,
                          accel_mag.z > high_lvl};
  wire [2:0] low_under = {accel_mag.x < low_lvl, accel_mag.y < low_lvl,
                          accel_mag.z < low_lvl};
  wire [2:0] fall_under = {accel_mag.x < fall_lvl, accel_mag.y < fall_lvl,
                           accel_mag.z < fall_lvl};

  wire tap_hit_now  = |(tap_over & tap_en);
  wire high_all_now = hlg_cfg_reg[`MEI_HIGH_ALL_BIT] && (|high_en) &&
                      ((high_over & high_en) == high_en);
  wire low_all_now  = hlg_cfg_reg[`MEI_LOW_ALL_BIT] && (&low_under);
  // A zero free-fall threshold can never be undercut, so it parks the detector
  wire fall_all_now = &fall_under;

  // Comparisons are held between samples
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tap_hit_reg  <= 1'b0;
      high_all_reg <= 1'b0;
      low_all_reg  <= 1'b0;
      fall_all_reg <= 1'b0;
      tap_prev_reg <= 1'b0;
    end else begin
      tap_prev_reg <= tap_hit_reg;
      if (sample_valid) begin
        tap_hit_reg  <= tap_hit_now;
        high_all_reg <= high_all_now;
        low_all_reg  <= low_all_now;
        fall_all_reg <= fall_all_now;
      end
    end
  end

  mei_dwell u_high (.clock(clock), .arst_n(arst_n), .cond(high_all_reg),
                    .tick(tick_reg), .limit(high_dur_reg), .fire(fire_high));
  mei_dwell u_low  (.clock(clock), .arst_n(arst_n), .cond(low_all_reg),
                    .tick(tick_reg), .limit(low_dur_reg), .fire(fire_low));
  mei_dwell u_fall (.clock(clock), .arst_n(arst_n), .cond(fall_all_reg),
                    .tick(tick_reg), .limit(fall_dur_reg), .fire(fire_fall));

  // Tap sequencer; a tap starts on a rising hit and must end within the duration
  wire hit_rise = tap_hit_reg && !tap_prev_reg;
  wire hit_fall = !tap_hit_reg && tap_prev_reg;
  wire dur_out  = ms_tick_reg && (tap_ms_reg == tap_dur_reg);

  always_comb begin
    tap_st_next = tap_st_reg;
    tap_ms_clr  = 1'b0;
    single_next = 1'b0;
    double_next = 1'b0;
    case (tap_st_reg)
      TAP_IDLE: begin
        if (hit_rise) begin
          tap_st_next = TAP_SHOCK1;
          tap_ms_clr  = 1'b1;
        end
      end
      TAP_SHOCK1: begin
        if (hit_fall) begin
          tap_st_next = TAP_LAT;
          tap_ms_clr  = 1'b1;
          single_next = 1'b1;
        end else if (dur_out) begin
          tap_st_next = TAP_IDLE;
        end
      end
      TAP_LAT: begin
        if (tap_ms_reg >= tap_lat_reg) begin
          tap_st_next = TAP_WIN;
          tap_ms_clr  = 1'b1;
        end
      end
      TAP_WIN: begin
        if (hit_rise) begin
          tap_st_next = TAP_SHOCK2;
          tap_ms_clr  = 1'b1;
        end else if (tap_ms_reg >= tap_win_reg) begin
          tap_st_next = TAP_IDLE;
        end
      end
      TAP_SHOCK2: begin
        if (hit_fall) begin
          tap_st_next = TAP_IDLE;
          double_next = 1'b1;
        end else if (dur_out) begin
          tap_st_next = TAP_IDLE;
        end
      end
      default: tap_st_next = TAP_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tap_st_reg <= TAP_IDLE;
      tap_ms_reg <= 8'h00;
    end else begin
      tap_st_reg <= tap_st_next;
      if (tap_ms_clr)
        tap_ms_reg <= 8'h00;
      else if (ms_tick_reg && tap_ms_reg != 8'hff)
        tap_ms_reg <= tap_ms_reg + 8'h01;
    end
  end

  // Activity link; the history tracks what was detected, reported or not
  wire link    = tap_cfg_reg[`MEI_LINK_BIT];
  wire act_ok  = !link || !prev_valid_reg || !prev_act_reg;
  wire inact_ok = !link || !prev_valid_reg || prev_act_reg;

  always_comb begin
    evt_next.single_tap = single_next;
    evt_next.double_tap = double_next;
    evt_next.high_g     = fire_high;
    evt_next.low_g      = fire_low;
    evt_next.free_fall  = fire_fall;
    evt_next.act        = act_detect && act_ok;
    evt_next.inact      = inact_detect && inact_ok;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      events         <= '0;
      prev_valid_reg <= 1'b0;
      prev_act_reg   <= 1'b0;
    end else begin
      events <= evt_next;
      if (act_detect) begin
        prev_valid_reg <= 1'b1;
        prev_act_reg   <= 1'b1;
      end else if (inact_detect) begin
        prev_valid_reg <= 1'b1;
        prev_act_reg   <= 1'b0;
      end
    end
  end

  tap_cfg_rsvd_a: assert property (@(posedge clock) disable iff (!arst_n)
    reg_req.rd && reg_req.addr == `MEI_ADDR_TAP_CFG |=> reg_rdata[7:4] == 4'h0)
    else $error("Tap config reserved bits not zero");
  tap_axis_gate_a: assert property (@(posedge clock) disable iff (!arst_n)
    $rose(tap_hit_reg) |-> $past(|tap_en))
    else $error("Tap hit with no axis enabled");
  link_block_a: assert property (@(posedge clock) disable iff (!arst_n)
    link && prev_valid_reg && prev_act_reg && $stable(link) |=> !events.act)
    else $error("Repeated activity with link set");
  unlinked_act_a: assert property (@(posedge clock) disable iff (!arst_n)
    !link && act_detect |=> events.act)
    else $error("Activity lost with link clear");
  tap_thr_write_a: assert property (@(posedge clock) disable iff (!arst_n)
    wr_tap_thr |=> tap_thr_reg == $past(reg_req.wdata))
    else $error("Tap threshold not stored");
  shock_limit_a: assert property (@(posedge clock) disable iff (!arst_n)
    tap_st_reg == TAP_SHOCK1 && !hit_fall && dur_out |=> tap_st_reg == TAP_IDLE)
    else $error("Long shock accepted as tap");
  latency_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
    tap_st_reg == TAP_LAT && tap_ms_reg < tap_lat_reg |=> tap_st_reg == TAP_LAT)
    else $error("Window opened before latency");
  double_src_a: assert property (@(posedge clock) disable iff (!arst_n)
    events.double_tap |-> $past(tap_st_reg, 2) == TAP_SHOCK2)
    else $error("Double tap outside second shock");
  // Held comparisons may outlive a config write, so only a fresh load is judged
  high_enable_a: assert property (@(posedge clock) disable iff (!arst_n)
    high_all_reg && $past(sample_valid) |-> $past(hlg_cfg_reg[`MEI_HIGH_ALL_BIT]))
    else $error("High-g armed while disabled");
  hlg_rsvd_a: assert property (@(posedge clock) disable iff (!arst_n)
    hlg_cfg_reg[3:1] == 3'h0)
    else $error("High/low-g reserved bits set");
endmodule

/* File: verification/mei_host_model.sv */
// Host model: byte writes and reads over the register port
`timescale 1ns/10ps

module mei_host
  import mei_pkg::*;
(
  input  wire logic         clock,
  input  wire logic [7:0]   reg_rdata,
  output mei_reg_req_t      reg_req
);
  initial reg_req = '0;

  // Released address and data show their inverse so a stale decode cannot pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clock);
    reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask

  // Read data is taken half a cycle after the edge that takes the request
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clock);
    d = reg_rdata;
    reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
  endtask
endmodule

/* File: verification/tb.sv */
// Self-checking testbench for the motion event block
`timescale 1ns/10ps
`include "mei_defines.svh"
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("mismatch %s expected %0h seen %0h", nm, exp, got); end end

module tb
  import mei_pkg::*;
;
  localparam int MS = 10;
  localparam int TK = 8;
  localparam int ST = 6;
  localparam int DT = 5;
  localparam int HG = 4;
  localparam int LG = 3;
  localparam int FF = 2;
  localparam int AC = 1;
  localparam int IN = 0;

  logic         clock        = 1'b0;
  logic         arst_n       = 1'b0;
  mei_reg_req_t reg_req;
  logic [7:0]   reg_rdata;
  logic         sample_valid = 1'b0;
  mei_axes_t    accel_mag    = '0;
  logic [1:0]   accel_range  = 2'h0;
  logic         act_detect   = 1'b0;
  logic         inact_detect = 1'b0;
  mei_events_t  events;
  int           cnt[7];
  int           num_errors   = 0;
  int           total_checks = 0;

  mei_motion_events #(.MS_CYCLES(MS), .TICK_CYCLES(TK)) u_mei_motion_events (
    .clock        (clock),
    .arst_n       (arst_n),
    .reg_req      (reg_req),
    .reg_rdata    (reg_rdata),
    .sample_valid (sample_valid),
    .accel_mag    (accel_mag),
    .accel_range  (accel_range),
    .act_detect   (act_detect),
    .inact_detect (inact_detect),
    .events       (events)
  );

  mei_host u_mei_host (
    .clock     (clock),
    .reg_rdata (reg_rdata),
    .reg_req   (reg_req)
  );

  always #10 clock = ~clock;

  // Samples every other cycle, as a one-cycle pulse
  always @(negedge clock) begin
    if (arst_n) sample_valid <= ~sample_valid;
  end

  // Pulses are counted, so a stuck-high event shows as a count above one
  always @(posedge clock) begin
    for (int i = 0; i < 7; i++) if (events[i] === 1'b1) cnt[i]++;
  end

  task automatic clr();
    foreach (cnt[i]) cnt[i] = 0;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic ax(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
    @(negedge clock);
    accel_mag <= {x, y, z};
  endtask

  task automatic t_regs();
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] m;
    for (int i = 0; i < 17; i++) begin
      a = 8'h50 + i[7:0];
      m = (a == `MEI_ADDR_TAP_CFG) ? `MEI_TAP_CFG_MASK :
          (a == `MEI_ADDR_HLG_CFG) ? `MEI_HLG_CFG_MASK :
          (a inside {[8'h55:8'h58], 8'h60}) ? 8'h00 : 8'hff;
      u_mei_host.rd(a, d);
      `CHK("reset value", 8'h00, d)
      u_mei_host.wr(a, 8'hff);
      u_mei_host.rd(a, d);
      `CHK("write mask", m, d)
      u_mei_host.wr(a, 8'h00);
    end
  endtask

  task automatic pulse(input logic act);
    @(negedge clock);
    if (act) act_detect <= 1'b1;
    else inact_detect <= 1'b1;
    @(negedge clock);
    act_detect <= 1'b0;
    inact_detect <= 1'b0;
    cyc(2);
  endtask

  task automatic t_link();
    u_mei_host.wr(`MEI_ADDR_TAP_CFG, 8'h01);
    clr();
    pulse(1'b1); pulse(1'b1); pulse(1'b0); pulse(1'b0); pulse(1'b1);
    `CHK("linked act", 2, cnt[AC])
    `CHK("linked inact", 1, cnt[IN])
    u_mei_host.wr(`MEI_ADDR_TAP_CFG, 8'h00);
    clr();
    pulse(1'b1); pulse(1'b1); pulse(1'b0); pulse(1'b0);
    `CHK("free act", 2, cnt[AC])
    `CHK("free inact", 2, cnt[IN])
  endtask

  // Dwell limit 3 ticks: no pulse may appear before two full ticks have passed
  task automatic hg(input logic [7:0] cfg, input logic [15:0] x, input logic [15:0] y,
                    input logic [15:0] z, input int exp);
    u_mei_host.wr(`MEI_ADDR_HLG_CFG, cfg);
    clr();
    ax(x, y, z);
    cyc(2 * TK - 4);
    `CHK("high early", 0, cnt[HG])
    cyc(5 * TK);
    `CHK("high pulse", exp, cnt[HG])
    ax(16'h0000, 16'h0000, 16'h0000);
    cyc(4);
  endtask

  task automatic t_high();
    logic [15:0] v;
    u_mei_host.wr(`MEI_ADDR_HIGH_THR, 8'h02);
    u_mei_host.wr(`MEI_ADDR_HIGH_DUR, 8'h03);
    for (int r = 0; r < 4; r++) begin
      accel_range <= r[1:0];
      for (int k = 0; k < 2; k++) begin
        v = (16'h0002 << r) + k[15:0];
        hg(8'hf0, v, v, v, k);
      end
    end
    accel_range <= 2'h0;
    hg(8'h70, 16'h0003, 16'h0003, 16'h0003, 0);
    hg(8'hc0, 16'h0003, 16'h0000, 16'h0000, 1);
    hg(8'hc0, 16'h0000, 16'h0003, 16'h0003, 0);
    hg(8'ha0, 16'h0000, 16'h0003, 16'h0000, 1);
    hg(8'h90, 16'h0000, 16'h0000, 16'h0003, 1);
    u_mei_host.wr(`MEI_ADDR_HLG_CFG, 8'h00);
  endtask

  task automatic t_low();
    u_mei_host.wr(`MEI_ADDR_LOW_THR, 8'h03);
    u_mei_host.wr(`MEI_ADDR_LOW_DUR, 8'h04);
    u_mei_host.wr(`MEI_ADDR_HLG_CFG, 8'h01);
    clr();
    // Each quiet spell is shorter than four ticks, so only a restart-free count fires
    repeat (4) begin
      ax(16'h0002, 16'h0002, 16'h0002);
      cyc(18);
      ax(16'h0009, 16'h0009, 16'h0009);
      cyc(6);
    end
    `CHK("low broken", 0, cnt[LG])
    ax(16'h0002, 16'h0002, 16'h0002);
    cyc(60);
    `CHK("low pulse", 1, cnt[LG])
    ax(16'h0009, 16'h0009, 16'h0009);
    u_mei_host.wr(`MEI_ADDR_HLG_CFG, 8'h00);
    u_mei_host.wr(`MEI_ADDR_FALL_THR, 8'h03);
    u_mei_host.wr(`MEI_ADDR_FALL_DUR, 8'h02);
    clr();
    ax(16'h0002, 16'h0002, 16'h0002);
    cyc(40);
    `CHK("fall pulse", 1, cnt[FF])
    `CHK("low disabled", 0, cnt[LG])
    ax(16'h0009, 16'h0009, 16'h0009);
    u_mei_host.wr(`MEI_ADDR_FALL_THR, 8'h00);
    ax(16'h0000, 16'h0000, 16'h0000);
  endtask

  task automatic shock(input logic [15:0] x, input logic [15:0] y, input int n);
    ax(x, y, 16'h0000);
    cyc(n);
    ax(16'h0000, 16'h0000, 16'h0000);
  endtask

  task automatic t_tap();
    u_mei_host.wr(`MEI_ADDR_TAP_CFG, 8'h08);
    u_mei_host.wr(`MEI_ADDR_TAP_THR, 8'h01);
    u_mei_host.wr(`MEI_ADDR_TAP_DUR, 8'h05);
    u_mei_host.wr(`MEI_ADDR_TAP_LAT, 8'h01);
    u_mei_host.wr(`MEI_ADDR_TAP_WIN, 8'h03);
    cyc(20);
    clr();
    shock(16'h0000, 16'h0005, 10);
    cyc(50);
    shock(16'h0001, 16'h0000, 10);
    cyc(50);
    shock(16'h0005, 16'h0000, 90);
    cyc(100);
    `CHK("tap refused", 0, cnt[ST])
    clr();
    shock(16'h0005, 16'h0000, 10);
    cyc(100);
    `CHK("single tap", 1, cnt[ST])
    `CHK("no double", 0, cnt[DT])
    clr();
    shock(16'h0005, 16'h0000, 10);
    cyc(15);
    shock(16'h0005, 16'h0000, 10);
    cyc(100);
    `CHK("double tap", 1, cnt[DT])
    clr();
    shock(16'h0005, 16'h0000, 10);
    cyc(80);
    shock(16'h0005, 16'h0000, 10);
    cyc(100);
    `CHK("late second", 0, cnt[DT])
    `CHK("two singles", 2, cnt[ST])
    // Second shock lands while the latency still runs, so it must be ignored
    u_mei_host.wr(`MEI_ADDR_TAP_LAT, 8'h04);
    clr();
    shock(16'h0005, 16'h0000, 10);
    cyc(15);
    shock(16'h0005, 16'h0000, 10);
    cyc(100);
    `CHK("tap in latency", 0, cnt[DT])
    `CHK("latency single", 1, cnt[ST])
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Whole run is a few thousand cycles; this span leaves wide margin
  initial begin
    #(20000 * 20);
    num_errors++;
    conclude();
  end

  initial begin
    clr();
    repeat (8) @(negedge clock);
    arst_n = 1'b1;
    t_regs();
    t_link();
    t_high();
    t_low();
    t_tap();
    conclude();
  end
endmodule
